// [hw/cwc_top.sv]
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does, and what its software must do
// RL1: Mode 101 push-pull; 110, 111 reserved.
// RL2: Mode 100 half-bridge with dead bands.
// RL3: Mode 011 reverse full-bridge.
// RL4: Enable bit 7, resets to zero.
// RL5: Load buffers on rise after first fall.
// RL6: Working buffers hold while load flag clear.
// RL7: Software keeps outputs as inputs while configuring.
// RL8: Software disables before changing configuration.
// RL9: Software programs steering before enabling.
// RL10: Enabling starts in shutdown, override levels.
// RL11: Software enables last, then outputs pins.
// RL12: Auto-restart clears shutdown on a data rise once condition gone.
// RL13: Without auto-restart software clears shutdown.
// RL14: Load flag not set with enable together.
// RL15: Disabled: dead-band write loads working buffer.
// RL16: Shutdown clear ignored while condition present.
// RL17: Modes 000, 001, 010 steering and forward.
// RL18: Control bits 5 to 3 read zero.
module cwc_top
  import cwc_pkg::*;
(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  // Pins
  input  wire logic             data_in,
  input  wire logic [SRC_N-1:0] shutdown_in_n,
  output logic [3:0]            wave_out,
  // Interrupt
  output logic                  irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic             en_r;
  logic             ld_r;
  logic [2:0]       mode_r;
  logic [3:0]       pol_r;
  logic [3:0]       steer_r;
  logic             sd_r;
  logic             sd_nxt;
  logic             ren_r;
  logic [1:0]       lvl2_r;
  logic [1:0]       lvl1_r;
  logic [SRC_N-1:0] src_en_r;
  logic [DB_W-1:0]  dbr_r;
  logic [DB_W-1:0]  dbf_r;
  logic [DB_W-1:0]  dbr_work_r;
  logic [DB_W-1:0]  dbf_work_r;
  logic [IRQ_N-1:0] irq_stat_r;
  logic [IRQ_N-1:0] irq_en_r;
  logic             run_r;
  cwc_ld_state_t    ld_st_r;
  cwc_ld_state_t    ld_st_nxt;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // A level is accepted only when the last two stages agree
  logic [2:0]       din_s_r;
  logic             din_r;
  logic             din_d_r;
  logic [SRC_N-1:0] sd_s1_r;
  logic [SRC_N-1:0] sd_s2_r;
  logic [SRC_N-1:0] sd_s3_r;
  logic [SRC_N-1:0] sd_lvl_n_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      din_s_r    <= 3'h0;
      din_r      <= 1'b0;
      din_d_r    <= 1'b0;
      sd_s1_r    <= {SRC_N{1'b1}};
      sd_s2_r    <= {SRC_N{1'b1}};
      sd_s3_r    <= {SRC_N{1'b1}};
      sd_lvl_n_r <= {SRC_N{1'b1}};
    end
    else
    begin
      din_s_r <= {din_s_r[1:0], data_in};
      if (din_s_r[1] == din_s_r[2])
        din_r <= din_s_r[2];
      din_d_r <= din_r;
      sd_s1_r <= shutdown_in_n;
      sd_s2_r <= sd_s1_r;
      sd_s3_r <= sd_s2_r;
      for (int i = 0; i < SRC_N; i++)
        if (sd_s2_r[i] == sd_s3_r[i])
          sd_lvl_n_r[i] <= sd_s3_r[i];
    end
  end

  wire data_rise = din_r & ~din_d_r;
  wire data_fall = ~din_r & din_d_r;
  // Shutdown inputs are level sensitive and active low
  wire sd_cond   = |(src_en_r & ~sd_lvl_n_r);

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states; the read word is fetched in the address phase
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_r;

  wire        addr_ph = hsel & hready & htrans[1];
  wire        rd_req  = addr_ph & ~hwrite;
  wire        wr_main = wr_pend_r & (wr_addr_r == OFS_MAIN);
  wire        wr_pol  = wr_pend_r & (wr_addr_r == OFS_POL);
  wire        wr_str  = wr_pend_r & (wr_addr_r == OFS_STEER);
  wire        wr_sdc  = wr_pend_r & (wr_addr_r == OFS_SDCTL);
  wire        wr_src  = wr_pend_r & (wr_addr_r == OFS_SDSRC);
  wire        wr_dbr  = wr_pend_r & (wr_addr_r == OFS_DBR);
  wire        wr_dbf  = wr_pend_r & (wr_addr_r == OFS_DBF);
  wire        wr_iclr = wr_pend_r & (wr_addr_r == OFS_IRQ_CLR);
  wire        wr_ien  = wr_pend_r & (wr_addr_r == OFS_IRQ_EN);
  wire [7:0]  rd_addr = haddr[7:0];

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h000000, v};
  endfunction

  logic [31:0] rd_mux;
  always_comb
  begin
    case (rd_addr)
      OFS_MAIN:     rd_mux = zext8({en_r, ld_r, 3'b000, mode_r}); // RL18
      OFS_POL:      rd_mux = zext8({2'b00, din_r, 1'b0, pol_r});
      OFS_STEER:    rd_mux = zext8({4'h0, steer_r});
      OFS_SDCTL:    rd_mux = zext8({sd_r, ren_r, lvl2_r, lvl1_r, 2'b00});
      OFS_SDSRC:    rd_mux = zext8({4'h0, src_en_r});
      OFS_DBR:      rd_mux = zext8({1'b0, dbr_r});
      OFS_DBF:      rd_mux = zext8({1'b0, dbf_r});
      OFS_IRQ_STAT: rd_mux = zext8({6'h00, irq_stat_r});
      OFS_IRQ_EN:   rd_mux = zext8({6'h00, irq_en_r});
      default:      rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h00000000;
    end
    else
    begin
      wr_pend_r <= addr_ph & hwrite;
      if (addr_ph)
        wr_addr_r <= haddr[7:0];
      if (rd_req)
        rdata_r <= rd_mux;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  wire en_set  = wr_main & hwdata[MAIN_EN_BIT] & ~en_r;
  // Load request accepted only once enable already stands
  wire ld_req  = wr_main & hwdata[MAIN_LD_BIT] & en_r; // RL5

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_r     <= 1'b0;
      mode_r   <= MODE_RST;
      pol_r    <= POL_RST;
      steer_r  <= 4'h0;
      ren_r    <= 1'b0;
      lvl2_r   <= 2'b00;
      lvl1_r   <= 2'b00;
      src_en_r <= {SRC_N{1'b0}};
      dbr_r    <= DB_RST;
      dbf_r    <= DB_RST;
      irq_en_r <= {IRQ_N{1'b0}};
    end
    else
    begin
      if (wr_main)
      begin
        en_r   <= hwdata[MAIN_EN_BIT]; // RL4
        mode_r <= hwdata[2:0];
      end
      if (wr_pol)
        pol_r <= hwdata[3:0];
      if (wr_str)
        steer_r <= hwdata[3:0];
      if (wr_sdc)
      begin
        ren_r  <= hwdata[SD_REN_BIT];
        lvl2_r <= hwdata[SD_LVL2_LO +: 2];
        lvl1_r <= hwdata[SD_LVL1_LO +: 2];
      end
      if (wr_src)
        src_en_r <= hwdata[SRC_N-1:0];
      if (wr_dbr)
        dbr_r <= hwdata[DB_W-1:0];
      if (wr_dbf)
        dbf_r <= hwdata[DB_W-1:0];
      if (wr_ien)
        irq_en_r <= hwdata[IRQ_N-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Dead-band buffer load
  // ----------------------------------------------------------------
  wire ld_done = (ld_st_r == CWC_LD_RISE) & data_rise & en_r;

  always_comb
  begin
    case (ld_st_r)
      CWC_LD_IDLE: ld_st_nxt = ld_req ? CWC_LD_FALL : CWC_LD_IDLE;
      CWC_LD_FALL: ld_st_nxt = data_fall ? CWC_LD_RISE : CWC_LD_FALL;
      CWC_LD_RISE: ld_st_nxt = data_rise ? CWC_LD_IDLE : CWC_LD_RISE;
      default:     ld_st_nxt = CWC_LD_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ld_st_r    <= CWC_LD_IDLE;
      ld_r       <= 1'b0;
      dbr_work_r <= DB_RST;
      dbf_work_r <= DB_RST;
    end
    else
    begin
      // Disabling abandons a pending load
      ld_st_r <= en_r ? ld_st_nxt : CWC_LD_IDLE;
      ld_r    <= en_r & (ld_st_nxt != CWC_LD_IDLE); // RL6
      if (!en_r)
      begin
        if (wr_dbr)
          dbr_work_r <= hwdata[DB_W-1:0]; // RL15
        if (wr_dbf)
          dbf_work_r <= hwdata[DB_W-1:0]; // RL15
      end
      else if (ld_done)
      begin
        dbr_work_r <= dbr_r; // RL5
        dbf_work_r <= dbf_r; // RL5
      end
    end
  end

  // ----------------------------------------------------------------
  // Shutdown and restart
  // ----------------------------------------------------------------
  // Any set beats any clear in the same cycle
  wire sd_set = sd_cond | en_set | (wr_sdc & hwdata[SD_FLAG_BIT]); // RL10
  wire sd_sw_clr   = wr_sdc & ~hwdata[SD_FLAG_BIT] & ~sd_cond;     // RL16
  wire sd_auto_clr = ren_r & en_r & ~sd_cond & data_rise;          // RL12

  always_comb
  begin
    sd_nxt = sd_r;
    if (sd_set)
      sd_nxt = 1'b1;
    else if (sd_sw_clr | sd_auto_clr)
      sd_nxt = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sd_r  <= 1'b0;
      run_r <= 1'b0;
    end
    else
    begin
      sd_r <= sd_nxt;
      // Waveforms resume only on a data rising edge after release
      if (!en_r || sd_nxt)
        run_r <= 1'b0;
      else if (data_rise && !sd_r)
        run_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire [IRQ_N-1:0] irq_ev  = {ld_done, sd_nxt & ~sd_r};
  wire [IRQ_N-1:0] irq_clr = wr_iclr ? hwdata[IRQ_N-1:0] : {IRQ_N{1'b0}};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_r <= {IRQ_N{1'b0}};
    else
      irq_stat_r <= irq_ev | (irq_stat_r & ~irq_clr);
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // ----------------------------------------------------------------
  // Waveform generator
  // ----------------------------------------------------------------
  cwc_wave_if wif ();

  assign wif.en        = en_r;
  assign wif.run       = run_r & ~sd_r; // RL10
  assign wif.data      = din_r;
  assign wif.data_rise = data_rise;
  assign wif.mode      = mode_r;
  assign wif.pol       = pol_r;
  assign wif.steer     = steer_r;
  assign wif.ovr       = {lvl2_r[1], lvl1_r[1], lvl2_r[0], lvl1_r[0]};
  assign wif.db_rise   = dbr_work_r;
  assign wif.db_fall   = dbf_work_r;
  assign wave_out      = wif.wave;

  cwc_wave u_wave (
    .hclk    (hclk),
    .hresetn (hresetn),
    .w       (wif)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_disabled_quiet;
    !en_r ##1 !en_r |=> wave_out == 4'h0;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) // RL4
    else $error("outputs active while disabled");

  property p_load_copy;
    ld_st_r == CWC_LD_RISE && data_rise && en_r
      |=> dbr_work_r == $past(dbr_r) && !ld_r;
  endproperty
  a_load_copy: assert property (p_load_copy) // RL5
    else $error("buffer load missed or flag not cleared");

  property p_hold;
    en_r && ld_st_r != CWC_LD_RISE |=> $stable(dbr_work_r);
  endproperty
  a_hold: assert property (p_hold) // RL6
    else $error("working buffer changed without load");

  property p_start_sd;
    $rose(en_r) |-> sd_r ##1 (wave_out == $past(wif.ovr));
  endproperty
  a_start_sd: assert property (p_start_sd) // RL10
    else $error("enable did not start in shutdown");

  property p_auto;
    ren_r && en_r && sd_r && !sd_cond && data_rise && !wr_sdc
      && !en_set |=> !sd_r;
  endproperty
  a_auto: assert property (p_auto) // RL12
    else $error("auto-restart did not clear shutdown");

  property p_direct;
    wr_dbr && !en_r |=> dbr_work_r == $past(hwdata[DB_W-1:0]);
  endproperty
  a_direct: assert property (p_direct) // RL15
    else $error("disabled write did not reach working buffer");

  property p_sw_clr;
    sd_r && sd_cond && wr_sdc |=> sd_r;
  endproperty
  a_sw_clr: assert property (p_sw_clr) // RL16
    else $error("shutdown cleared with condition present");

  property p_rsvd;
    rd_req && rd_addr == OFS_MAIN |=> hrdata[5:3] == 3'b000;
  endproperty
  a_rsvd: assert property (p_rsvd) // RL18
    else $error("unimplemented control bits read nonzero");

  c_load:  cover property (ld_done);
  c_auto:  cover property (sd_r && sd_auto_clr ##1 !sd_r);
  c_sd_ev: cover property (en_r && !sd_r ##1 sd_r);
  c_irq:   cover property (irq);

endmodule
`default_nettype wire

// [hw/cwc_wave.sv]
`timescale 1ns/1ps
`default_nettype none
module cwc_wave
  import cwc_pkg::*;
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Control side
  cwc_wave_if.gen   w
);

  logic [DB_W-1:0] cnt_r;
  logic [DB_W-1:0] dcnt_r;
  logic            data_d_r;
  logic            tog_r;
  logic [3:0]      steer_r;
  logic [2:0]      mode_d_r;
  logic [3:0]      wave_r;
  logic [3:0]      raw;
  logic [3:0]      drive;

  // Edge counter restarts on each data edge; dead band measured from it
  wire       data_edge = w.data ^ data_d_r;
  wire       dir_chg   = (w.mode != mode_d_r);
  // Age is zero in the edge cycle, so a stale count cannot glitch
  wire [DB_W-1:0] age  = data_edge ? DB_RST : cnt_r;
  wire [DB_W-1:0] dage = dir_chg ? DB_RST : dcnt_r;
  wire       a_ok      = w.data & (age >= w.db_rise);
  wire       b_ok      = ~w.data & (age >= w.db_fall);
  wire       rev_ok    = dage >= w.db_rise;
  wire       fwd_ok    = dage >= w.db_fall;
  wire [3:0] steer_sel = (w.mode == MODE_SSTEER) ? steer_r : w.steer;

  always_comb
  begin
    case (w.mode)
      MODE_ASTEER, MODE_SSTEER: raw = steer_sel & {4{w.data}}; // RL17
      MODE_FWD:  raw = {w.data & fwd_ok, 2'b00, 1'b1};          // RL17
      MODE_REV:  raw = {1'b0, 1'b1, w.data & rev_ok, 1'b0};     // RL3
      MODE_HALF: raw = {2'b00, b_ok, a_ok};                     // RL2
      MODE_PP:   raw = {2'b00, w.data & ~tog_r, w.data & tog_r}; // RL1
      default:   raw = 4'h0;                                    // RL1
    endcase
  end

  // Shutdown or waiting for first rising edge: override levels
  assign drive  = w.run ? (raw ^ w.pol) : w.ovr;
  assign w.wave = wave_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r    <= DB_RST;
      dcnt_r   <= DB_RST;
      data_d_r <= 1'b0;
      tog_r    <= 1'b0;
      steer_r  <= 4'h0;
      mode_d_r <= MODE_RST;
      wave_r   <= 4'h0;
    end
    else
    begin
      data_d_r <= w.data;
      mode_d_r <= w.mode;
      cnt_r    <= data_edge ? 7'h01
                : (&cnt_r) ? cnt_r : cnt_r + 7'h01;
      dcnt_r   <= dir_chg ? 7'h01
                : (&dcnt_r) ? dcnt_r : dcnt_r + 7'h01;
      if (w.data_rise)
      begin
        tog_r   <= ~tog_r;
        steer_r <= w.steer;
      end
      wave_r   <= w.en ? drive : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire [3:0] act = wave_r ^ w.pol;

  property p_pp_pair;
    w.en && w.run && w.mode == MODE_PP |=> !(act[0] && act[1]) && !act[3];
  endproperty
  a_pp_pair: assert property (p_pp_pair) // RL1
    else $error("push-pull drove both or a bridge output");

  property p_reserved;
    w.en && w.run && w.mode > MODE_PP |=> wave_r == w.pol;
  endproperty
  a_reserved: assert property (p_reserved) // RL1
    else $error("reserved mode drove an output");

  property p_half;
    w.en && w.run && w.mode == MODE_HALF |=> !(act[0] && act[1]);
  endproperty
  a_half: assert property (p_half) // RL2
    else $error("half-bridge overlap");

  property p_rev;
    w.en && w.run && w.mode == MODE_REV |=> act[2] && !act[0];
  endproperty
  a_rev: assert property (p_rev) // RL3
    else $error("reverse full-bridge wrong static pair");

  property p_fwd;
    w.en && w.run && w.mode == MODE_FWD |=> act[0] && !act[2];
  endproperty
  a_fwd: assert property (p_fwd) // RL17
    else $error("forward full-bridge wrong static pair");

  property p_asteer;
    w.en && w.run && w.mode == MODE_ASTEER
      |=> act == ($past(w.steer) & {4{$past(w.data)}});
  endproperty
  a_asteer: assert property (p_asteer) // RL17
    else $error("asynchronous steering mismatch");

  c_pp_run: cover property (w.en && w.run && w.mode == MODE_PP ##1 act[1]);

endmodule
`default_nettype wire

// [include/cwc_pkg.sv]
package cwc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN     = 8'h00;
  localparam logic [7:0] OFS_POL      = 8'h04;
  localparam logic [7:0] OFS_STEER    = 8'h08;
  localparam logic [7:0] OFS_SDCTL    = 8'h0c;
  localparam logic [7:0] OFS_SDSRC    = 8'h10;
  localparam logic [7:0] OFS_DBR      = 8'h14;
  localparam logic [7:0] OFS_DBF      = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MAIN_EN_BIT   = 7;
  localparam int MAIN_LD_BIT   = 6;
  localparam int POL_IN_BIT    = 5;
  localparam int SD_FLAG_BIT   = 7;
  localparam int SD_REN_BIT    = 6;
  localparam int SD_LVL2_LO    = 4;
  localparam int SD_LVL1_LO    = 2;
  localparam int IRQ_SD_BIT    = 0;
  localparam int IRQ_LOAD_BIT  = 1;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int DB_W   = 7;
  localparam int SRC_N  = 4;
  localparam int IRQ_N  = 2;
  localparam logic [2:0]      MODE_RST = 3'h0;
  localparam logic [3:0]      POL_RST  = 4'h0;
  localparam logic [DB_W-1:0] DB_RST   = 7'h00;

  // Output mode codes
  localparam logic [2:0] MODE_ASTEER = 3'h0;
  localparam logic [2:0] MODE_SSTEER = 3'h1;
  localparam logic [2:0] MODE_FWD    = 3'h2;
  localparam logic [2:0] MODE_REV    = 3'h3;
  localparam logic [2:0] MODE_HALF   = 3'h4;
  localparam logic [2:0] MODE_PP     = 3'h5;

  // Buffer load sequence
  typedef enum logic [2:0] {
    CWC_LD_IDLE = 3'b001,
    CWC_LD_FALL = 3'b010,
    CWC_LD_RISE = 3'b100
  } cwc_ld_state_t;

endpackage

// [include/cwc_wave_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cwc_wave_if;
  import cwc_pkg::*;
  logic            en;
  logic            run;
  logic            data;
  logic            data_rise;
  logic [2:0]      mode;
  logic [3:0]      pol;
  logic [3:0]      steer;
  logic [3:0]      ovr;
  logic [DB_W-1:0] db_rise;
  logic [DB_W-1:0] db_fall;
  logic [3:0]      wave;

  modport ctl  (output en, run, data, data_rise, mode, pol, steer, ovr,
                db_rise, db_fall, input wave);
  modport gen  (input en, run, data, data_rise, mode, pol, steer, ovr,
                db_rise, db_fall, output wave);
endinterface
`default_nettype wire

// [tb/cwc_drv_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Power stage stand-in
// ----------------------------------------
module cwc_drv_model
(
  // Clock
  input  wire logic       hclk,
  // Gate drive from the block
  input  wire logic [3:0] wave_out,
  // Modulation source and fault lines
  output logic            data_in,
  output logic [3:0]      shutdown_in_n
);
  logic chk_on;
  int   xing;

  initial
  begin
    data_in       = 1'b0;
    shutdown_in_n = 4'hf;
    xing          = 0;
  end

  // Fault lines are pulled up: idle means no fault
  task automatic drive(input logic d, input logic [3:0] f);
    @(posedge hclk);
    data_in       <= d;
    shutdown_in_n <= f;
  endtask

  // Both switches of leg A/B on together shorts the rail
  always @(posedge hclk)
    if (chk_on && wave_out[0] === 1'b1 && wave_out[1] === 1'b1)
      xing <= xing + 1;
endmodule
`default_nettype wire

// [tb/tb_complementary_waveform_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_complementary_waveform_control;
  import cwc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        data_in, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [3:0]  sd_n, wave_out;
  int          errors, n_checks, d, d2, d10;

  assign hready = hreadyout;

  cwc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .data_in(data_in), .shutdown_in_n(sd_n), .wave_out(wave_out),
    .irq(irq));

  cwc_drv_model u_drv (.hclk(hclk), .wave_out(wave_out),
    .data_in(data_in), .shutdown_in_n(sd_n));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic rdy();
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hready !== 1'b1 && i < 16);
    if (hready !== 1'b1)
    begin
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] wd);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    v = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(a, 1'b1, wd);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk(v & m, e);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge hclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // Cycles from data rise to output A on, then a full low phase
  task automatic measure(output int n);
    u_drv.drive(1'b1, 4'hf);
    n = 0;
    while (wave_out[0] !== 1'b1 && n < 200)
    begin
      @(negedge hclk);
      n++;
    end
    if (n >= 200)
    begin
      errors++;
      tally_and_finish();
    end
    repeat (20) @(posedge hclk);
    u_drv.drive(1'b0, 4'hf);
    repeat (20) @(posedge hclk);
  endtask

  // One data level held 30 cycles, long enough for the dead bands programmed here to expire
  task automatic phase(input logic dv, output logic [3:0] w);
    u_drv.drive(dv, 4'hf);
    repeat (30) @(negedge hclk);
    w = wave_out;
  endtask

  task automatic t_mode(input logic [31:0] md, input logic [31:0] st,
                        input logic [31:0] hi, input logic [31:0] lo);
    logic [3:0] w1;
    logic [3:0] w0;
    logic [3:0] w2;
    wr(OFS_MAIN, md);
    wr(OFS_STEER, st);
    wr(OFS_MAIN, 32'h80 | md);
    wr(OFS_SDCTL, 32'h04);
    phase(1'b1, w1);
    phase(1'b0, w0);
    phase(1'b1, w2);
    phase(1'b0, w0);
    chk({28'h0, w0}, lo);
    if (md == 32'(MODE_PP))
    begin
      chk({28'h0, w1 | w2}, hi);
      chk({28'h0, w1 ^ w2}, hi);
    end
    else
    begin
      chk({28'h0, w1}, hi);
      chk({28'h0, w2}, hi);
    end
  endtask

  task automatic run_hb(input logic [31:0] db, output int n);
    wr(OFS_MAIN, 32'h04);
    wr(OFS_DBR, db);
    wr(OFS_DBF, 32'h03);
    wr(OFS_SDCTL, 32'h04);
    wr(OFS_SDSRC, 32'h0);
    wr(OFS_MAIN, 32'h84);
    rd(OFS_SDCTL, 32'h80, 32'h80);
    chk({28'h0, wave_out}, 32'h1);
    wr(OFS_SDCTL, 32'h04);
    measure(n);
    measure(n);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(OFS_MAIN, 32'hffffffff, 32'h0);
    chk_irq(1'b0);
    wr(OFS_MAIN, 32'hc0);
    rd(OFS_MAIN, 32'hff, 32'h80);
    for (int m = 0; m < 8; m++)
    begin
      wr(OFS_MAIN, 32'h38 | 32'(m));
      rd(OFS_MAIN, 32'hff, 32'(m));
    end
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'hffffffff, 32'h0);
  endtask

  task automatic t_deadband();
    run_hb(32'd10, d10);
    run_hb(32'd2, d2);
    chk(32'(d10 - d2), 32'd8);
  endtask

  task automatic t_load();
    wr(OFS_IRQ_CLR, 32'h3);
    wr(OFS_IRQ_EN, 32'h2);
    wr(OFS_DBR, 32'd12);
    measure(d);
    chk(32'(d), 32'(d2));
    wr(OFS_MAIN, 32'hc4);
    rd(OFS_MAIN, 32'hff, 32'hc4);
    measure(d);
    chk(32'(d), 32'(d2));
    rd(OFS_MAIN, 32'hff, 32'hc4);
    measure(d);
    rd(OFS_MAIN, 32'hff, 32'h84);
    rd(OFS_IRQ_STAT, 32'h2, 32'h2);
    chk_irq(1'b1);
    wr(OFS_IRQ_EN, 32'h0);
    chk_irq(1'b0);
    wr(OFS_IRQ_CLR, 32'h2);
    rd(OFS_IRQ_STAT, 32'h2, 32'h0);
    wr(OFS_IRQ_EN, 32'h2);
    chk_irq(1'b0);
    measure(d);
    chk(32'(d), 32'(d2 + 10));
  endtask

  task automatic t_shutdown();
    wr(OFS_SDSRC, 32'h1);
    u_drv.drive(1'b0, 4'he);
    repeat (8) @(posedge hclk);
    wr(OFS_SDCTL, 32'h04);
    rd(OFS_SDCTL, 32'h80, 32'h80);
    chk({28'h0, wave_out}, 32'h1);
    u_drv.drive(1'b0, 4'hf);
    repeat (8) @(posedge hclk);
    wr(OFS_SDCTL, 32'h04);
    rd(OFS_SDCTL, 32'h80, 32'h0);
    wr(OFS_SDCTL, 32'h44);
    u_drv.drive(1'b0, 4'he);
    repeat (8) @(posedge hclk);
    rd(OFS_SDCTL, 32'h80, 32'h80);
    u_drv.drive(1'b0, 4'hf);
    repeat (8) @(posedge hclk);
    measure(d);
    rd(OFS_SDCTL, 32'h80, 32'h0);
  endtask

  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial
  begin
    errors   = 0;
    n_checks = 0;
    hresetn  = 1'b0;
    hsel     = 1'b1;
    haddr    = 32'h0;
    htrans   = 2'b00;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    u_drv.chk_on = 1'b1;
    t_regs();
    t_deadband();
    t_load();
    t_shutdown();
    t_mode(32'h5, 32'h0, 32'h3, 32'h0);
    t_mode(32'h3, 32'h0, 32'h6, 32'h4);
    t_mode(32'h2, 32'h0, 32'h9, 32'h1);
    t_mode(32'h0, 32'h5, 32'h5, 32'h0);
    t_mode(32'h1, 32'ha, 32'ha, 32'h0);
    t_mode(32'h6, 32'h0, 32'h0, 32'h0);
    chk(32'(u_drv.xing), 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
